// ===== acjae_pkg.sv
// Shared constants and types for the page call / jump / add execution slice.
// Assumes a single 125 MHz clk_sys domain and a Wishbone classic register bus.
package acjae_pkg;

    // Clocks per machine cycle, and machine cycles per instruction class
    localparam int MC_CLKS = 12;
    localparam int BRANCH_CYCLES = 2;
    localparam int ADD_CYCLES = 1;

    // Page call and page jump: low five opcode bits, target page width
    localparam logic [4:0] OPL_CALL = 5'h11;
    localparam logic [4:0] OPL_JUMP = 5'h01;
    localparam int PAGE_BITS = 11;

    // Add forms (full opcode, or leading bits where a register is encoded)
    localparam logic [7:0] OP_ADD_IMM = 8'h24;
    localparam logic [7:0] OP_ADD_DIR = 8'h25;
    localparam logic [6:0] OP_ADD_IND = 7'h13;
    localparam logic [4:0] OP_ADD_REG = 5'h05;
    localparam logic [7:0] OP_AWC_IMM = 8'h34;
    localparam logic [7:0] OP_AWC_DIR = 8'h35;
    localparam logic [6:0] OP_AWC_IND = 7'h1B;
    localparam logic [4:0] OP_AWC_REG = 5'h07;

    // Register byte offsets and data RAM window
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_PROG = 12'h008;
    localparam logic [11:0] REG_ACCUM = 12'h00C;
    localparam logic [11:0] REG_STACK = 12'h010;
    localparam logic [11:0] REG_FLAGS = 12'h014;
    localparam logic [1:0] RAM_WIN = 2'h1;

    // Field positions
    localparam int CTRL_RUN = 0;
    localparam int CTRL_STEP = 1;
    localparam int STAT_BUSY = 0;
    localparam int STAT_BADOP = 1;
    localparam int FLAG_PAR = 0;
    localparam int FLAG_OVF = 2;
    localparam int FLAG_AUX = 6;
    localparam int FLAG_CY = 7;

    // Reset values
    localparam logic [15:0] PROG_RST = 16'h0000;
    localparam logic [7:0] STACK_RST = 8'h07;
    localparam logic [7:0] ACCUM_RST = 8'h00;

    // Arithmetic flags carried from the adder to the core
    typedef struct packed {
        logic cy;
        logic aux;
        logic ovf;
        logic par;
    } acjae_flags_s;

    // Sequencer states
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_OP = 3'b001,
        S_ARG = 3'b010,
        S_EXEC = 3'b011,
        S_PUSHL = 3'b100,
        S_PUSHH = 3'b101,
        S_WAIT = 3'b110
    } acjae_state_e;

endpackage

// ===== acjae_alu.sv
// Eight-bit adder with carry in and the four arithmetic flags.
// Assumes operands and carry in are stable within one clk_sys cycle.
`timescale 1ns/100ps
module acjae_alu (
    // Operands
    input wire logic [7:0] opA,
    input wire logic [7:0] opB,
    input wire logic carryIn,
    // Results
    output logic [7:0] sum,
    output acjae_pkg::acjae_flags_s flags
);
    logic [8:0] sum9;
    logic [4:0] low5;

    // Full sum and low nibble sum
    assign sum9 = {1'h0, opA} + {1'h0, opB} + {8'h00, carryIn};
    assign low5 = {1'h0, opA[3:0]} + {1'h0, opB[3:0]} + {4'h0, carryIn};
    assign sum = sum9[7:0];

    // Flag outputs
    assign flags.cy = sum9[8];
    assign flags.aux = low5[4];
    assign flags.ovf = (opA[7] == opB[7]) && (sum9[7] != opA[7]);
    assign flags.par = ^sum9[7:0];
endmodule

// ===== acjae_core.sv
// Execution slice for page call, page jump, add and add_with_carry.
// Assumes a combinational program memory on progAddr/progData in the clk_sys
// domain and software access over a Wishbone classic slave.
// Notes on behaviour
// - A page call first advances the program counter by two.
// - Call then increments stack pointer and pushes the counter's low byte.
// - Call increments stack pointer again and pushes the counter's high byte.
// - Call ends by loading counter bits 10..0 with the page address.
// - Page jump loads counter bits 10..0 only; stack and memory untouched.
// - Target bits 10..8 from opcode bits 7..5, bits 7..0 from byte two.
// - Targets are eleven bits, staying in the incremented counter's 2K page.
// - Call and jump take two machine cycles, every add form one.
// - Opcode 24h adds the following immediate byte to the accumulator.
// - Opcode 26h/27h adds the RAM byte addressed by register 0 or 1.
// - Opcodes 28h..2Fh add working register 0..7 to the accumulator.
// - Opcode 25h adds the RAM byte at the following direct address.
// - Adds update parity, overflow, aux carry, carry; call and jump don't.
// - add_with_carry also adds carry; opcodes 34h, 36h/37h, 38h..3Fh, 35h.
`timescale 1ns/100ps
module acjae_core (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Program memory fetch
    output logic [15:0] progAddr,
    input wire logic [7:0] progData,
    // Status
    output logic coreBusy,
    output logic instrDone
);
    acjae_pkg::acjae_state_e state_q, state_d;
    acjae_pkg::acjae_flags_s flags_q, flags_d, aluFlags;
    logic [15:0] programCounter_q, programCounter_d;
    logic [7:0] stackPointer_q, stackPointer_d;
    logic [7:0] acc_q, acc_d;
    logic [7:0] opcode_q, operandByte_q;
    logic [15:0] progAddr_q;
    logic [3:0] divCnt_q;
    logic [1:0] mcCnt_q;
    logic [7:0] clkSince_q;
    logic runEn_q, stepReq_q, badOp_q, ack_q;
    logic [31:0] rdData_q;
    logic [7:0] ram_q [0:255];
    logic ramWe;
    logic [7:0] ramWAddr, ramWData;
    // Machine cycle divider
    wire mcTick = divCnt_q == 4'(acjae_pkg::MC_CLKS - 1);
    // Bus decode
    wire busReq = wb_cyc_i && wb_stb_i && !ack_q;
    wire busWr = busReq && wb_we_i;
    wire selCtrl = wb_adr_i == acjae_pkg::REG_CTRL;
    wire selStat = wb_adr_i == acjae_pkg::REG_STATUS;
    wire selProg = wb_adr_i == acjae_pkg::REG_PROG;
    wire selAcc = wb_adr_i == acjae_pkg::REG_ACCUM;
    wire selStack = wb_adr_i == acjae_pkg::REG_STACK;
    wire selFlags = wb_adr_i == acjae_pkg::REG_FLAGS;
    wire selRam = wb_adr_i[11:10] == acjae_pkg::RAM_WIN;
    wire [7:0] ramIdx = wb_adr_i[9:2];
    wire isIdle = state_q == acjae_pkg::S_IDLE;
    wire coreWr = busWr && isIdle && wb_sel_i[0];
    // Opcode decode
    wire isCall = opcode_q[4:0] == acjae_pkg::OPL_CALL;
    wire isJump = opcode_q[4:0] == acjae_pkg::OPL_JUMP;
    wire isImm = opcode_q == acjae_pkg::OP_ADD_IMM || opcode_q == acjae_pkg::OP_AWC_IMM;
    wire isDir = opcode_q == acjae_pkg::OP_ADD_DIR || opcode_q == acjae_pkg::OP_AWC_DIR;
    wire isInd = opcode_q[7:1] == acjae_pkg::OP_ADD_IND
        || opcode_q[7:1] == acjae_pkg::OP_AWC_IND;
    wire isReg = opcode_q[7:3] == acjae_pkg::OP_ADD_REG
        || opcode_q[7:3] == acjae_pkg::OP_AWC_REG;
    wire isAdd = isImm || isDir || isInd || isReg;
    wire withCarry = opcode_q[4];
    wire [1:0] opCycles = (isCall || isJump) ? 2'(acjae_pkg::BRANCH_CYCLES)
        : 2'(acjae_pkg::ADD_CYCLES);
    // Page target and counter increments
    wire [10:0] pageAddr = {opcode_q[7:5], operandByte_q};
    wire [15:0] pcPlus1 = programCounter_q + 16'h0001;
    wire [15:0] pcPlus2 = programCounter_q + 16'h0002;
    wire [7:0] spPlus1 = stackPointer_q + 8'h01;
    // Operand selection from RAM, register bank or immediate byte
    wire [7:0] indPtr = ram_q[{7'h00, opcode_q[0]}];
    wire [7:0] regVal = ram_q[{5'h00, opcode_q[2:0]}];
    wire [7:0] operand = isImm ? operandByte_q
        : isDir ? ram_q[operandByte_q]
        : isInd ? ram_q[indPtr] : regVal;
    wire [7:0] aluSum;
    // Retirement and start of the next instruction
    wire lastCycle = (mcCnt_q + 2'h1) == opCycles;
    wire waitDone = state_q == acjae_pkg::S_WAIT && mcTick && lastCycle;
    wire goReq = runEn_q || stepReq_q;
    wire startNow = mcTick && goReq && ((isIdle && !busWr) || waitDone);
    acjae_alu u_alu (
        .opA(acc_q),
        .opB(operand),
        .carryIn(withCarry && flags_q.cy),
        .sum(aluSum),
        .flags(aluFlags)
    );
    // Sequencer and architectural next state
    always_comb begin
        state_d = state_q;
        programCounter_d = programCounter_q;
        stackPointer_d = stackPointer_q;
        acc_d = acc_q;
        flags_d = flags_q;
        ramWe = 1'h0;
        ramWAddr = spPlus1;
        ramWData = programCounter_q[7:0];
        case (state_q)
            acjae_pkg::S_IDLE: begin
                if (startNow) begin
                    state_d = acjae_pkg::S_OP;
                end
            end
            acjae_pkg::S_OP: state_d = acjae_pkg::S_ARG;
            acjae_pkg::S_ARG: state_d = acjae_pkg::S_EXEC;
            acjae_pkg::S_EXEC: begin
                state_d = acjae_pkg::S_WAIT;
                if (isCall) begin
                    programCounter_d = pcPlus2;
                    state_d = acjae_pkg::S_PUSHL;
                end else if (isJump) begin
                    programCounter_d = {pcPlus2[15:11], pageAddr};
                end else if (isAdd) begin
                    acc_d = aluSum;
                    flags_d = aluFlags;
                    programCounter_d = (isImm || isDir) ? pcPlus2 : pcPlus1;
                end else begin
                    programCounter_d = pcPlus1;
                end
            end
            acjae_pkg::S_PUSHL: begin
                stackPointer_d = spPlus1;
                ramWe = 1'h1;
                state_d = acjae_pkg::S_PUSHH;
            end
            acjae_pkg::S_PUSHH: begin
                stackPointer_d = spPlus1;
                ramWe = 1'h1;
                ramWData = programCounter_q[15:8];
                programCounter_d = {programCounter_q[15:11], pageAddr};
                state_d = acjae_pkg::S_WAIT;
            end
            acjae_pkg::S_WAIT: begin
                if (waitDone) begin
                    state_d = startNow ? acjae_pkg::S_OP : acjae_pkg::S_IDLE;
                end
            end
            default: state_d = acjae_pkg::S_IDLE;
        endcase
        // Software access to core state only while the core is idle
        if (coreWr && selProg) begin
            programCounter_d[7:0] = wb_dat_i[7:0];
        end
        if (busWr && isIdle && selProg && wb_sel_i[1]) begin
            programCounter_d[15:8] = wb_dat_i[15:8];
        end
        if (coreWr && selAcc) begin
            acc_d = wb_dat_i[7:0];
        end
        if (coreWr && selStack) begin
            stackPointer_d = wb_dat_i[7:0];
        end
        if (coreWr && selFlags) begin
            flags_d = {wb_dat_i[acjae_pkg::FLAG_CY], wb_dat_i[acjae_pkg::FLAG_AUX],
                wb_dat_i[acjae_pkg::FLAG_OVF], wb_dat_i[acjae_pkg::FLAG_PAR]};
        end
        if (coreWr && selRam) begin
            ramWe = 1'h1;
            ramWAddr = ramIdx;
            ramWData = wb_dat_i[7:0];
        end
    end

    // Architectural state
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state_q <= acjae_pkg::S_IDLE;
            programCounter_q <= acjae_pkg::PROG_RST;
            stackPointer_q <= acjae_pkg::STACK_RST;
            acc_q <= acjae_pkg::ACCUM_RST;
            flags_q <= '0;
        end else begin
            state_q <= state_d;
            programCounter_q <= programCounter_d;
            stackPointer_q <= stackPointer_d;
            acc_q <= acc_d;
            flags_q <= flags_d;
        end
    end

    // Data RAM, working registers at the bottom
    always_ff @(posedge clk_sys) begin
        if (ramWe) begin
            ram_q[ramWAddr] <= ramWData;
        end
    end

    // Fetch address and latched instruction bytes
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            progAddr_q <= acjae_pkg::PROG_RST;
            opcode_q <= 8'h00;
            operandByte_q <= 8'h00;
        end else begin
            if (startNow) begin
                progAddr_q <= programCounter_q;
            end else if (state_q == acjae_pkg::S_OP) begin
                progAddr_q <= pcPlus1;
            end
            if (state_q == acjae_pkg::S_OP) begin
                opcode_q <= progData;
            end
            if (state_q == acjae_pkg::S_ARG) begin
                operandByte_q <= progData;
            end
        end
    end

    // Machine cycle divider and per-instruction counters
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            divCnt_q <= 4'h0;
            mcCnt_q <= 2'h0;
            clkSince_q <= 8'h00;
        end else begin
            divCnt_q <= mcTick ? 4'h0 : divCnt_q + 4'h1;
            if (startNow) begin
                mcCnt_q <= 2'h0;
            end else if (mcTick && state_q == acjae_pkg::S_WAIT) begin
                mcCnt_q <= mcCnt_q + 2'h1;
            end
            clkSince_q <= startNow ? 8'h00 : clkSince_q + 8'h01;
        end
    end

    // Control and sticky status; a set beats a clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            runEn_q <= 1'h0;
            stepReq_q <= 1'h0;
            badOp_q <= 1'h0;
        end else begin
            if (busWr && selCtrl && wb_sel_i[0]) begin
                runEn_q <= wb_dat_i[acjae_pkg::CTRL_RUN];
            end
            if (busWr && selCtrl && wb_sel_i[0] && wb_dat_i[acjae_pkg::CTRL_STEP]) begin
                stepReq_q <= 1'h1;
            end else if (startNow) begin
                stepReq_q <= 1'h0;
            end
            if (state_q == acjae_pkg::S_EXEC && !(isCall || isJump || isAdd)) begin
                badOp_q <= 1'h1;
            end else if (busWr && selStat && wb_sel_i[0] && wb_dat_i[acjae_pkg::STAT_BADOP]) begin
                badOp_q <= 1'h0;
            end
        end
    end

    // Read data selection
    wire [7:0] flagByte = {flags_q.cy, flags_q.aux, 3'h0, flags_q.ovf, 1'h0, flags_q.par};
    wire [31:0] rdMux = selCtrl ? {30'h0, stepReq_q, runEn_q}
        : selStat ? {16'h0, opcode_q, 6'h0, badOp_q, !isIdle}
        : selProg ? {16'h0, programCounter_q}
        : selAcc ? {24'h0, acc_q}
        : selStack ? {24'h0, stackPointer_q}
        : selFlags ? {24'h0, flagByte}
        : selRam ? {24'h0, ram_q[ramIdx]} : 32'h0;
    // Bus acknowledge and registered read data
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ack_q <= 1'h0;
            rdData_q <= 32'h0;
        end else begin
            ack_q <= busReq;
            if (busReq) begin
                rdData_q <= rdMux;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdData_q;
    assign progAddr = progAddr_q;
    assign coreBusy = !isIdle;
    assign instrDone = waitDone;
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    a_call_pc_adv: assert property (state_q == acjae_pkg::S_EXEC && isCall
        |=> programCounter_q == $past(pcPlus2) && state_q == acjae_pkg::S_PUSHL)
        else $error("call did not advance counter by two");
    a_push_low_byte: assert property (state_q == acjae_pkg::S_PUSHL
        |-> ramWe && ramWAddr == spPlus1 && ramWData == programCounter_q[7:0]
        ##1 stackPointer_q == $past(spPlus1))
        else $error("low byte push wrong");
    a_push_high_byte: assert property (state_q == acjae_pkg::S_PUSHL
        ##1 state_q == acjae_pkg::S_PUSHH |-> ramWe && ramWData == programCounter_q[15:8]
        && ramWAddr == $past(stackPointer_q) + 8'h02)
        else $error("high byte push wrong");
    a_call_page_load: assert property (state_q == acjae_pkg::S_PUSHH
        |=> programCounter_q[10:0] == $past(pageAddr)
        && programCounter_q[15:11] == $past(programCounter_q[15:11]))
        else $error("call target not loaded");
    a_jump_page_only: assert property (state_q == acjae_pkg::S_EXEC && isJump
        |=> programCounter_q == {$past(pcPlus2[15:11]), $past(pageAddr)}
        && $stable(stackPointer_q) && !$past(ramWe))
        else $error("jump touched more than the page bits");
    a_target_decode: assert property (state_q == acjae_pkg::S_EXEC && (isCall || isJump)
        |-> pageAddr == {$past(progData[7:5], 2), $past(progData)})
        else $error("page address decode wrong");
    a_cycle_length: assert property (instrDone
        |-> clkSince_q == 8'(opCycles * acjae_pkg::MC_CLKS - 1))
        else $error("instruction length in machine cycles wrong");
    a_branch_flags_hold: assert property (state_q == acjae_pkg::S_EXEC
        && (isCall || isJump) |=> $stable(flags_q) [*3])
        else $error("branch changed flags");
    a_add_sum_carry: assert property (state_q == acjae_pkg::S_EXEC && isAdd
        |=> {flags_q.cy, acc_q} == {1'h0, $past(acc_q)} + {1'h0, $past(operand)}
        + {8'h00, $past(withCarry) && $past(flags_q.cy)})
        else $error("add result or carry wrong");
    a_add_parity: assert property (state_q == acjae_pkg::S_EXEC && isAdd
        |=> flags_q.par == ^acc_q)
        else $error("parity flag wrong after add");
    c_page_call: cover property (state_q == acjae_pkg::S_PUSHH);
    c_page_jump: cover property (state_q == acjae_pkg::S_EXEC && isJump);
    c_carry_add: cover property (state_q == acjae_pkg::S_EXEC && isAdd && withCarry && flags_q.cy);
    c_back_to_back: cover property (instrDone && startNow);
endmodule

// ===== acjae_prog_mem.sv
// Program memory model facing the execution slice's fetch port.
// Assumes a combinational read in the clk_sys domain; the bench loads bytes.
`timescale 1ns/100ps
module acjae_prog_mem (
    // Fetch port
    input wire logic [15:0] progAddr,
    output logic [7:0] progData
);
    logic [7:0] mem [0:65535];

    // Same-cycle read; unloaded bytes read unknown, as a blank part would
    assign progData = mem[progAddr];

    // Bench loader for one byte
    task automatic put(input logic [15:0] a, input logic [7:0] d);
        mem[a] = d;
    endtask
endmodule

// ===== abs_call_jump_add_exec_tb.sv
// Self-checking bench for the page call, page jump and add execution slice.
// Assumes acjae_core with a Wishbone classic slave and acjae_prog_mem.
`timescale 1ns/100ps
module abs_call_jump_add_exec_tb;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic wbCyc = 1'b0;
    logic wbStb = 1'b0;
    logic wbWe = 1'b0;
    logic [11:0] wbAdr = 12'h000;
    logic [3:0] wbSel = 4'h0;
    logic [31:0] wbDatW = 32'h0;
    logic [31:0] wbDatR;
    logic wbAck;
    logic [15:0] progAddr;
    logic [7:0] progData;
    logic coreBusy;
    logic instrDone;
    logic [7:0] mram [0:255];
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;

    // Design under test and its program memory
    acjae_core u_acjae_core (.clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
        .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
        .progAddr(progAddr), .progData(progData), .coreBusy(coreBusy),
        .instrDone(instrDone));
    acjae_prog_mem u_acjae_prog_mem (.progAddr(progAddr), .progData(progData));

    // 125 MHz clock
    always #4 clk_sys = ~clk_sys;

    // Hang guard
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One classic cycle; holds everything until ack is sampled high
    task automatic wb_cycle(input logic we, input logic [11:0] adr,
        input logic [31:0] dat, output logic [31:0] rd);
        @(posedge clk_sys);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbSel <= 4'hF;
        wbDatW <= dat;
        @(posedge clk_sys);
        while (wbAck !== 1'b1) @(posedge clk_sys);
        rd = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
    endtask

    task automatic wb_write(input logic [11:0] adr, input logic [31:0] dat);
        logic [31:0] rd;
        wb_cycle(1'b1, adr, dat, rd);
    endtask

    task automatic rd_chk(input logic [11:0] adr, input logic [31:0] exp);
        logic [31:0] rd;
        wb_cycle(1'b0, adr, 32'h0, rd);
        check(rd, exp);
    endtask

    // Data RAM byte write, mirrored in the bench's shadow copy
    task automatic ram_wr(input logic [7:0] a, input logic [7:0] d);
        mram[a] = d;
        wb_write(12'h400 + {2'h0, a, 2'h0}, {24'h0, d});
    endtask

    task automatic wait_done();
        @(posedge clk_sys);
        while (instrDone !== 1'b1) @(posedge clk_sys);
    endtask

    task automatic wait_idle();
        repeat (2) @(posedge clk_sys);
        while (coreBusy !== 1'b0) @(posedge clk_sys);
    endtask

    task automatic step_one();
        wb_write(acjae_pkg::REG_CTRL, 32'h2);
        wait_done();
        wait_idle();
    endtask

    // Reset values and an unmapped read
    task automatic test_reset();
        rd_chk(acjae_pkg::REG_PROG, 32'h0000);
        rd_chk(acjae_pkg::REG_STACK, 32'h07);
        rd_chk(acjae_pkg::REG_ACCUM, 32'h00);
        rd_chk(12'h0FC, 32'h0);
    endtask

    // Call across a page boundary: pushes 0800h, lands in the new page
    task automatic test_call();
        ram_wr(8'h08, 8'hFF);
        ram_wr(8'h09, 8'hFF);
        ram_wr(8'h0A, 8'h3C);
        wb_write(acjae_pkg::REG_FLAGS, 32'hC5);
        wb_write(acjae_pkg::REG_PROG, 32'h07FE);
        u_acjae_prog_mem.put(16'h07FE, 8'hB1);
        u_acjae_prog_mem.put(16'h07FF, 8'h34);
        step_one();
        rd_chk(acjae_pkg::REG_PROG, 32'h0D34);
        rd_chk(acjae_pkg::REG_STACK, 32'h09);
        rd_chk(12'h420, 32'h00);
        rd_chk(12'h424, 32'h08);
        rd_chk(acjae_pkg::REG_FLAGS, 32'hC5);
    endtask

    // Jump touches only the counter's low eleven bits
    task automatic test_jump();
        u_acjae_prog_mem.put(16'h0D34, 8'h61);
        u_acjae_prog_mem.put(16'h0D35, 8'h12);
        step_one();
        rd_chk(acjae_pkg::REG_PROG, 32'h0B12);
        rd_chk(acjae_pkg::REG_STACK, 32'h09);
        rd_chk(12'h428, 32'h3C);
        rd_chk(acjae_pkg::REG_FLAGS, 32'hC5);
    endtask

    // Spacing of retirements while running freely
    task automatic run_gap(input logic [15:0] pc, input int exp);
        int n;
        wb_write(acjae_pkg::REG_PROG, {16'h0, pc});
        wb_write(acjae_pkg::REG_CTRL, 32'h1);
        wait_done();
        n = 0;
        @(posedge clk_sys);
        n++;
        while (instrDone !== 1'b1 && n < 100) begin
            @(posedge clk_sys);
            n++;
        end
        check(n, exp);
        wb_write(acjae_pkg::REG_CTRL, 32'h0);
        wait_idle();
    endtask

    task automatic test_timing();
        u_acjae_prog_mem.put(16'h0B12, 8'h61);
        u_acjae_prog_mem.put(16'h0B13, 8'h12);
        run_gap(16'h0B12, 24);
        ram_wr(8'h00, 8'h11);
        for (int k = 0; k < 16; k++) u_acjae_prog_mem.put(16'h0200 + 16'(k), 8'h28);
        run_gap(16'h0200, 12);
    endtask

    // Every add form, with and without carry, against a worked result
    task automatic test_adds();
        logic [7:0] ops [8];
        logic [7:0] op, b2, a, b, s;
        logic [15:0] pc;
        logic ci, cin, co, ax, ov;
        ops = '{8'h24, 8'h25, 8'h26, 8'h2F, 8'h34, 8'h35, 8'h37, 8'h38};
        ram_wr(8'h00, 8'h20);
        ram_wr(8'h01, 8'h21);
        ram_wr(8'h07, 8'h5A);
        ram_wr(8'h20, 8'h7F);
        ram_wr(8'h21, 8'h80);
        ram_wr(8'h30, 8'h99);
        for (int i = 0; i < 8; i++) begin
            op = ops[i];
            a = 8'h48 + 8'(i * 29);
            ci = (i % 2 == 1);
            b2 = (op[3:0] == 4'h5) ? 8'h30 : 8'h8F;
            if (op[3:0] == 4'h4) b = b2;
            else if (op[3:0] == 4'h5) b = mram[b2];
            else if (op[3:1] == 3'b011) b = mram[mram[{7'h0, op[0]}]];
            else b = mram[{5'h0, op[2:0]}];
            cin = op[4] & ci;
            {co, s} = {1'b0, a} + {1'b0, b} + {8'h0, cin};
            ax = ({1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin}) > 5'h0F;
            ov = (a[7] == b[7]) && (s[7] != a[7]);
            pc = 16'h0100 + 16'(i * 4);
            u_acjae_prog_mem.put(pc, op);
            u_acjae_prog_mem.put(pc + 16'h1, b2);
            wb_write(acjae_pkg::REG_PROG, {16'h0, pc});
            wb_write(acjae_pkg::REG_ACCUM, {24'h0, a});
            wb_write(acjae_pkg::REG_FLAGS, {24'h0, ci, 7'h0});
            step_one();
            rd_chk(acjae_pkg::REG_ACCUM, {24'h0, s});
            rd_chk(acjae_pkg::REG_FLAGS, {24'h0, co, ax, 3'h0, ov, 1'b0, ^s});
            pc = pc + ((op[3:1] == 3'b010) ? 16'h2 : 16'h1);
            rd_chk(acjae_pkg::REG_PROG, {16'h0, pc});
        end
    endtask

    // Unknown opcode: one-byte no-op that sets the sticky status bit
    task automatic test_badop();
        u_acjae_prog_mem.put(16'h0300, 8'hA5);
        u_acjae_prog_mem.put(16'h0301, 8'h00);
        wb_write(acjae_pkg::REG_PROG, 32'h0300);
        step_one();
        rd_chk(acjae_pkg::REG_PROG, 32'h0301);
        rd_chk(acjae_pkg::REG_STATUS, 32'hA502);
        wb_write(acjae_pkg::REG_STATUS, 32'h2);
        rd_chk(acjae_pkg::REG_STATUS, 32'hA500);
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        test_reset();
        test_call();
        test_jump();
        test_timing();
        test_badop();
        test_adds();
        give_verdict();
    end
endmodule
